// ===== core/hpb_host_port.sv
// Host port bus interface: two I/O ports, interrupt, mailbox, bus master.
// Assumes host strobes are synchronous one-cycle pulses on sys_clk_in.
`default_nettype none
module hpb_host_port
  import hpb_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int LEVELS         = IRQ_LEVELS
)
(
  input  wire logic                    sys_clk_in,
  input  wire logic                    arst_n_in,
  input  wire logic                    clk_en_in,
  // Host I/O slave side
  input  wire logic [ADDR_W-1:0]       io_addr_in,
  input  wire logic                    io_rd_in,
  input  wire logic                    io_wr_in,
  input  wire logic [7:0]              io_wdata_in,
  output logic [7:0]                   io_rdata_out,
  output logic                         io_ack_out,
  input  wire logic                    mem_rd_in,
  input  wire logic                    mem_wr_in,
  // Straps
  input  wire logic                    wide_decode_select_in,
  input  wire logic                    narrow_decode_select_in,
  input  wire logic [LOW_STRAP_W-1:0]  port_addr_low_straps_in,
  input  wire logic [HIGH_STRAP_W-1:0] port_addr_high_straps_in,
  input  wire logic [LEVELS-1:0]       irq_level_straps_in,
  input  wire logic                    priority_out_connect_in,
  input  wire logic                    common_req_honour_in,
  input  wire logic                    common_req_forced_in,
  input  wire logic                    bus_timeout_enable_in,
  // Board side
  input  wire logic                    selftest_pass_in,
  input  wire logic                    loopback_fail_in,
  input  wire logic                    host_irq_req_in,
  input  wire logic                    mailbox_take_in,
  output logic [7:0]                   mailbox_data_out,
  output logic                         cpu_irq_out,
  output logic                         board_reset_out,
  // Master request from on-board software
  input  wire logic                    mst_req_in,
  input  wire logic                    mst_io_in,
  input  wire logic                    mst_write_in,
  input  wire logic                    mst_wide_in,
  input  wire logic [MEM_ADDR_W-1:0]   mst_addr_in,
  input  wire logic [DATA_W-1:0]       mst_wdata_in,
  output logic                         mst_done_out,
  output logic                         mst_timeout_out,
  output logic [DATA_W-1:0]            mst_rdata_out,
  // Master bus side
  input  wire logic                    bus_prio_in_n_in,
  input  wire logic                    bus_busy_n_in,
  input  wire logic                    bus_xack_in,
  input  wire logic                    bus_cbrq_n_in,
  input  wire logic [DATA_W-1:0]       bus_rdata_in,
  output logic                         bus_req_out,
  output logic                         bus_prio_out_n_out,
  output logic                         bus_busy_oe_out,
  output logic [MEM_ADDR_W-1:0]        bus_addr_out,
  output logic [DATA_W-1:0]            bus_wdata_out,
  output logic                         bus_data_oe_out,
  output logic                         bus_mrd_out,
  output logic                         bus_mwr_out,
  output logic                         bus_iord_out,
  output logic                         bus_iowr_out,
  output logic                         bus_byte_out,
  output logic [LEVELS-1:0]            int_level_oe_out,
  output logic                         bus_cycle_indicator_out
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                  selftest_ok;
    logic                  irq_pend;
    logic                  mbox_full;
    logic [7:0]            mbox;
    logic [7:0]            rdata;
    logic                  ack;
    logic [7:0]            rst_cnt;
    hpb_mst_t              mst;
    logic                  release_bus;
    logic [31:0]           tmo_cnt;
    logic                  done;
    logic                  tmo;
    logic [DATA_W-1:0]     mrdata;
    logic [MEM_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]     wdata;
    logic                  io_cyc;
    logic                  wr_cyc;
    logic                  wide_cyc;
  } hpb_state_t;

  hpb_state_t st;
  hpb_state_t next_st;
  logic       hit;
  logic       port_sel;
  logic       rd_a;
  logic       wr_a;
  logic       rd_b;
  logic       wr_b;
  logic       cbrq_active;
  logic       in_cycle;
  logic [7:0] status;

  // ---------------------------------------------------------------
  // Leaf modules
  // ---------------------------------------------------------------
  hpb_decode u_decode (
    .io_addr_in               (io_addr_in),
    .port_addr_low_straps_in  (port_addr_low_straps_in),
    .port_addr_high_straps_in (port_addr_high_straps_in),
    .wide_decode_select_in    (wide_decode_select_in),
    .narrow_decode_select_in  (narrow_decode_select_in),
    .hit_out                  (hit),
    .port_sel_out             (port_sel)
  );

  hpb_irq_sel #(.LEVELS(LEVELS)) u_irq ( // Strap 3 fitted by default gives level 5
    .irq_level_straps_in (irq_level_straps_in),
    .irq_in              (st.irq_pend),
    .int_level_oe_out    (int_level_oe_out)
  );

  // ---------------------------------------------------------------
  // Port decode; memory strobes never reach this logic
  // ---------------------------------------------------------------
  assign rd_a = hit & io_rd_in & (port_sel == PORT_RESET_ACK);
  assign rd_b = hit & io_rd_in & (port_sel == PORT_STATUS_MB);
  assign wr_a = hit & io_wr_in & (port_sel == PORT_RESET_ACK);
  assign wr_b = hit & io_wr_in & (port_sel == PORT_STATUS_MB);

  // Status byte with undefined bits tied low for stable polling
  always_comb
  begin
    status              = 8'h00;
    status[ST_SELFTEST] = st.selftest_ok;
    status[ST_IRQ]      = st.irq_pend;
    status[ST_BUSY]     = st.mbox_full;
    status[ST_LOOPBACK] = loopback_fail_in;
  end

  // Common request input is ignored unless the honour strap is fitted and the forced strap is not
  assign cbrq_active = common_req_forced_in | ~common_req_honour_in | ~bus_cbrq_n_in;
  assign in_cycle    = (st.mst == HPB_CYCLE);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st      = st;
    next_st.ack  = 1'b0;
    next_st.done = 1'b0;
    next_st.tmo  = 1'b0;
    // Self-test flag cleared during reset pulse, set once firmware passes
    if (st.rst_cnt != 8'h00)
    begin
      next_st.rst_cnt     = st.rst_cnt - 8'h01;
      next_st.selftest_ok = 1'b0;
    end
    else if (selftest_pass_in)
      next_st.selftest_ok = 1'b1;
    // Host interrupt: a new request wins over a same-cycle acknowledge
    if (wr_a)
      next_st.irq_pend = 1'b0;
    if (host_irq_req_in)
      next_st.irq_pend = 1'b1;
    // Mailbox: CPU take clears, host write sets and wins
    if (mailbox_take_in)
      next_st.mbox_full = 1'b0;
    if (wr_b)
    begin
      next_st.mbox      = io_wdata_in;
      next_st.mbox_full = 1'b1;
    end
    // Host reads and writes are answered in the next cycle
    if (rd_a | rd_b | wr_a | wr_b)
    begin
      next_st.ack   = 1'b1;
      next_st.rdata = rd_b ? status : 8'h00;
    end
    if (rd_a)
    begin
      next_st.rst_cnt     = 8'(RESET_PULSE_CYC);
      next_st.selftest_ok = 1'b0;
      next_st.irq_pend    = 1'b0;
      next_st.mbox_full   = 1'b0;
    end
    // Master sequencer: one bus tenure per command
    case (st.mst)
      HPB_IDLE:
      begin
        if (mst_req_in)
        begin
          next_st.addr     = mst_addr_in;
          next_st.wdata    = mst_wdata_in;
          next_st.io_cyc   = mst_io_in;
          next_st.wr_cyc   = mst_write_in;
          next_st.wide_cyc = mst_wide_in;
          next_st.mst      = HPB_REQ;
        end
      end
      HPB_REQ:
      begin
        if (!bus_prio_in_n_in && bus_busy_n_in)
        begin
          next_st.mst     = HPB_CYCLE;
          next_st.tmo_cnt = 32'h0;
        end
      end
      HPB_CYCLE:
      begin
        next_st.tmo_cnt = st.tmo_cnt + 32'h1;
        if (bus_xack_in)
        begin
          next_st.mrdata = bus_rdata_in;
          next_st.done   = 1'b1;
          next_st.mst    = HPB_DONE;
        end
        else if (bus_timeout_enable_in && st.tmo_cnt >= 32'(TIMEOUT_CYCLES - 1))
        begin
          next_st.done = 1'b1;
          next_st.tmo  = 1'b1;
          next_st.mst  = HPB_DONE;
        end
      end
      HPB_DONE:
        next_st.mst = HPB_IDLE;
      default:
        next_st.mst = HPB_IDLE;
    endcase
    // Release-when-done flag is set after a command only while the common request is active
    next_st.release_bus = (st.mst == HPB_DONE) & cbrq_active;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st         <= '0;
      st.mst     <= HPB_IDLE;
      st.rst_cnt <= 8'(RESET_PULSE_CYC);
    end
    else if (clk_en_in)
      st <= next_st;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign io_rdata_out     = st.rdata;
  assign io_ack_out       = st.ack;
  assign mailbox_data_out = st.mbox;
  assign cpu_irq_out      = st.mbox_full;
  assign board_reset_out  = (st.rst_cnt != 8'h00);
  assign mst_done_out     = st.done;
  assign mst_timeout_out  = st.tmo;
  assign mst_rdata_out    = st.mrdata;
  // Bus request held from request through cycle only
  assign bus_req_out      = (st.mst == HPB_REQ) | in_cycle;
  // Priority out asserted low while requesting, only if the strap connects it
  assign bus_prio_out_n_out = ~(priority_out_connect_in & bus_req_out);
  assign bus_busy_oe_out  = in_cycle;
  assign bus_addr_out     = st.addr;
  assign bus_wdata_out    = st.wdata;
  assign bus_data_oe_out  = in_cycle & st.wr_cyc;
  assign bus_mrd_out      = in_cycle & ~st.io_cyc & ~st.wr_cyc;
  assign bus_mwr_out      = in_cycle & ~st.io_cyc &  st.wr_cyc;
  assign bus_iord_out     = in_cycle &  st.io_cyc & ~st.wr_cyc;
  assign bus_iowr_out     = in_cycle &  st.io_cyc &  st.wr_cyc;
  assign bus_byte_out     = ~st.wide_cyc;
  assign bus_cycle_indicator_out = in_cycle;
  // Memory strobes are accepted but never answered
  logic unused_mem;
  assign unused_mem = mem_rd_in | mem_wr_in;
endmodule : hpb_host_port
`default_nettype wire

// ===== core/hpb_pkg.sv
// Package for the host port bus interface: port offsets, status bit positions,
// master cycle states and timing constants.
// Assumes a single 20 MHz system clock domain.
`default_nettype none
package hpb_pkg;
  // ---------------------------------------------------------------
  // Port map
  // ---------------------------------------------------------------
  localparam logic [0:0] PORT_RESET_ACK = 1'h0; // reset_and_irq_ack_port
  localparam logic [0:0] PORT_STATUS_MB = 1'h1; // status_and_mailbox_port
  localparam int         ADDR_W         = 16;
  localparam int         LOW_STRAP_W    = 7;
  localparam int         HIGH_STRAP_W   = 8;
  localparam int         LOW_LSB        = 1;
  localparam int         HIGH_LSB       = 8;
  // ---------------------------------------------------------------
  // Status byte layout
  // ---------------------------------------------------------------
  localparam int ST_SELFTEST = 0;
  localparam int ST_IRQ      = 1;
  localparam int ST_BUSY     = 3;
  localparam int ST_LOOPBACK = 6;
  // ---------------------------------------------------------------
  // Interrupt levels and master bus
  // ---------------------------------------------------------------
  localparam int             IRQ_LEVELS   = 8;
  localparam logic [7:0]     IRQ_DEFAULT  = 8'h04; // Strap 3 -> level 5
  localparam int             MEM_ADDR_W   = 24;
  localparam int             DATA_W       = 16;
  localparam int             RESET_PULSE_NS = 500;
  localparam int             CLK_NS       = 50;
  localparam int             RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int             TIMEOUT_US   = 100;
  localparam int             TIMEOUT_CYC  = (TIMEOUT_US * 1000) / CLK_NS;
  // Master cycle states
  typedef enum logic [1:0] {HPB_IDLE, HPB_REQ, HPB_CYCLE, HPB_DONE} hpb_mst_t;
endpackage : hpb_pkg
`default_nettype wire

// ===== core/hpb_decode.sv
// Port address decoder: compares the host I/O address with the address straps.
// Assumes the address and strap inputs are stable and synchronous to the clock.
`default_nettype none
module hpb_decode
  import hpb_pkg::*;
(
  input  wire logic [ADDR_W-1:0]       io_addr_in,
  input  wire logic [LOW_STRAP_W-1:0]  port_addr_low_straps_in,
  input  wire logic [HIGH_STRAP_W-1:0] port_addr_high_straps_in,
  input  wire logic                    wide_decode_select_in,
  input  wire logic                    narrow_decode_select_in,
  output logic                         hit_out,
  output logic                         port_sel_out
);
  // ---------------------------------------------------------------
  // Compare
  // ---------------------------------------------------------------
  logic low_match;
  logic high_match;
  logic mode_ok;
  // Straps give logic one when installed, zero when absent
  assign low_match  = io_addr_in[LOW_LSB +: LOW_STRAP_W] == port_addr_low_straps_in;
  assign high_match = io_addr_in[HIGH_LSB +: HIGH_STRAP_W] == port_addr_high_straps_in;
  // A contradictory strap pair decodes nothing rather than guessing
  assign mode_ok = wide_decode_select_in ^ narrow_decode_select_in;
  always_comb
  begin
    if (wide_decode_select_in)
      hit_out = mode_ok & low_match & high_match; // 16-bit compare
    else
      hit_out = mode_ok & low_match;               // 8-bit compare uses bits 1-7
  end
  // Bit 0 is never strapped: low picks port A, high picks port B
  assign port_sel_out = io_addr_in[0];
endmodule : hpb_decode
`default_nettype wire

// ===== core/hpb_irq_sel.sv
// Interrupt level selector: routes the board interrupt to one bus level.
// Assumes the level straps are static; at most one should be installed.
`default_nettype none
module hpb_irq_sel
  import hpb_pkg::*;
#(
  parameter int LEVELS = IRQ_LEVELS
)
(
  input  wire logic [LEVELS-1:0] irq_level_straps_in,
  input  wire logic              irq_in,
  output logic [LEVELS-1:0]      int_level_oe_out
);
  // ---------------------------------------------------------------
  // Level routing
  // ---------------------------------------------------------------
  // Strap position n (1-based) drives level 8 minus n
  genvar g;
  generate
    for (g = 0; g < LEVELS; g++)
    begin : g_lvl
      assign int_level_oe_out[LEVELS-1-g] = irq_in & irq_level_straps_in[g];
    end
  endgenerate
endmodule : hpb_irq_sel
`default_nettype wire

// ===== bench/hpb_host_port_properties.sv
// Checker for the host port block, watching only its top-level ports.
// Assumes one clock domain and the asynchronous active-low board reset.
`default_nettype none
module hpb_prop
  import hpb_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int LEVELS         = IRQ_LEVELS
)
(
  input wire logic              sys_clk_in,
  input wire logic              arst_n_in,
  input wire logic [ADDR_W-1:0] io_addr_in,
  input wire logic              io_rd_in,
  input wire logic              io_wr_in,
  input wire logic [7:0]        io_wdata_in,
  input wire logic [7:0]        io_rdata_out,
  input wire logic              io_ack_out,
  input wire logic              loopback_fail_in,
  input wire logic [7:0]        mailbox_data_out,
  input wire logic              cpu_irq_out,
  input wire logic              board_reset_out,
  input wire logic              mst_done_out,
  input wire logic              bus_req_out,
  input wire logic              bus_mrd_out,
  input wire logic              bus_mwr_out,
  input wire logic              bus_iord_out,
  input wire logic              bus_iowr_out,
  input wire logic              bus_timeout_enable_in,
  input wire logic              bus_cycle_indicator_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  // ----------------------------------------------------------
  // Cycle length counter
  // ----------------------------------------------------------
  // Counter, since the default timeout is far beyond a delay range
  int cyc_len;
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in) cyc_len <= 0;
    else cyc_len <= bus_cycle_indicator_out ? cyc_len + 1 : 0;
  end
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  a_port_a_reset: assert property (io_ack_out && $past(io_rd_in) && !$past(io_addr_in[0])
    |-> ##[0:1] board_reset_out) else $error("port A read gave no board reset");
  a_status_spare: assert property (io_ack_out && $past(io_rd_in) && $past(io_addr_in[0])
    |-> (io_rdata_out & 8'hB4) == 8'h00) else $error("spare status bits set");
  a_loopback_bit: assert property (io_ack_out && $past(io_rd_in) && $past(io_addr_in[0])
    |-> io_rdata_out[ST_LOOPBACK] == $past(loopback_fail_in))
    else $error("loopback bit wrong");
  a_mailbox_latch: assert property (io_ack_out && $past(io_wr_in) && $past(io_addr_in[0])
    |-> cpu_irq_out && mailbox_data_out == $past(io_wdata_in))
    else $error("mailbox not latched");
  a_ack_discard: assert property (io_ack_out && $past(io_wr_in) && !$past(io_addr_in[0])
    |-> $stable(mailbox_data_out)) else $error("port A write reached mailbox");
  a_cycle_lamp: assert property ((bus_mrd_out || bus_mwr_out || bus_iord_out || bus_iowr_out)
    |-> bus_cycle_indicator_out) else $error("cycle indicator off in cycle");
  a_release_done: assert property (mst_done_out |-> !bus_req_out && !bus_cycle_indicator_out)
    else $error("bus held after done");
  a_timeout_bound: assert property (bus_timeout_enable_in |-> cyc_len <= TIMEOUT_CYCLES + 2)
    else $error("master cycle overran timeout");
endmodule : hpb_prop
bind hpb_host_port hpb_prop #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .LEVELS(LEVELS)) u_hpb_prop (
  .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .io_addr_in(io_addr_in),
  .io_rd_in(io_rd_in), .io_wr_in(io_wr_in), .io_wdata_in(io_wdata_in),
  .io_rdata_out(io_rdata_out), .io_ack_out(io_ack_out), .loopback_fail_in(loopback_fail_in),
  .mailbox_data_out(mailbox_data_out), .cpu_irq_out(cpu_irq_out),
  .board_reset_out(board_reset_out), .mst_done_out(mst_done_out), .bus_req_out(bus_req_out),
  .bus_mrd_out(bus_mrd_out), .bus_mwr_out(bus_mwr_out), .bus_iord_out(bus_iord_out),
  .bus_iowr_out(bus_iowr_out), .bus_timeout_enable_in(bus_timeout_enable_in),
  .bus_cycle_indicator_out(bus_cycle_indicator_out));
`default_nettype wire

// ===== bench/hpb_bus_model.sv
// Far side of the master bus: arbiter that grants on request and a slave.
// Assumes the bench drives no_ack_in and slow_in between master commands.
`default_nettype none
module hpb_bus_model
(
  input  wire logic        clk_in,
  input  wire logic        no_ack_in,
  input  wire logic        slow_in,
  input  wire logic        bus_req_in,
  input  wire logic [3:0]  strobes_in,
  input  wire logic [23:0] bus_addr_in,
  output logic             bus_prio_in_n_out,
  output logic             bus_busy_n_out,
  output logic             bus_xack_out,
  output logic [15:0]      bus_rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  logic [3:0] tick = 4'h0;
  // Grant at once; no other master holds the bus
  assign bus_prio_in_n_out = !bus_req_in;
  assign bus_busy_n_out = 1'b1;
  // Wait states count from the strobe; a missing slave never acknowledges
  always @(posedge clk_in)
  begin
    cnt <= (|strobes_in) ? cnt + 1 : 0;
    tick <= tick + 4'h1;
  end
  assign bus_xack_out = (|strobes_in) && !no_ack_in && cnt >= (slow_in ? 5 : 1);
  // Undriven data toggles every cycle so a stale capture shows up
  assign bus_rdata_out = bus_xack_out ? bus_addr_in[15:0] ^ 16'h5A5A : {4{tick}};
endmodule : hpb_bus_model
`default_nettype wire

// ===== bench/hpb_host_port_tb.sv
// Self-checking bench for the host port block with a bus model beside it.
// Assumes a 20 MHz clock; the bus timeout is shortened to 8 cycles.
`default_nettype none
module hpb_host_port_tb;
  import hpb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [33:0] DEC [7] = '{ // addr, wide, narrow, low, high, ack
    {16'h0001, 2'b10, 7'h00, 8'h00, 1'b1}, {16'h0003, 2'b10, 7'h00, 8'h00, 1'b0},
    {16'h0101, 2'b10, 7'h00, 8'h00, 1'b0}, {16'h0101, 2'b01, 7'h00, 8'h00, 1'b1},
    {16'h120B, 2'b10, 7'h05, 8'h12, 1'b1}, {16'h120B, 2'b11, 7'h05, 8'h12, 1'b0},
    {16'h120B, 2'b00, 7'h05, 8'h12, 1'b0}};
  logic sys_clk_in, arst_n_in, io_rd_in, io_wr_in, mem_rd_in, wide, narrow, st_pass, lb_fail;
  logic host_irq, take, mst_req, m_io, m_wr, m_wide, no_ack, slow, ack, bw, tmo;
  logic [15:0] io_addr_in, rdata;
  logic [7:0]  io_wdata_in, q, lvl, oe, mb_data, io_rdata_out;
  logic [6:0]  low;
  logic [7:0]  high;
  logic [23:0] m_addr, asn, b_addr;
  logic [3:0]  seen;
  logic io_ack_out, cpu_irq, brst, done, m_tmo, b_req, prio_n, busy_n, xack, mrd, mwr, iord;
  logic iowr, byte_n, lamp, mem_wr, clk_en, prio_con, prio_o, pl;
  logic [15:0] m_rdata, b_rdata, wd;
  int errors = 0;
  int n_compared = 0;
  int i;
  hpb_host_port #(.TIMEOUT_CYCLES(8)) u_hpb_host_port (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .clk_en_in(clk_en),
    .io_addr_in(io_addr_in), .io_rd_in(io_rd_in), .io_wr_in(io_wr_in),
    .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out), .io_ack_out(io_ack_out),
    .mem_rd_in(mem_rd_in), .mem_wr_in(mem_wr), .wide_decode_select_in(wide),
    .narrow_decode_select_in(narrow), .port_addr_low_straps_in(low),
    .port_addr_high_straps_in(high), .irq_level_straps_in(lvl),
    .priority_out_connect_in(prio_con), .common_req_honour_in(1'b0), .common_req_forced_in(1'b1),
    .bus_timeout_enable_in(1'b1), .selftest_pass_in(st_pass), .loopback_fail_in(lb_fail),
    .host_irq_req_in(host_irq), .mailbox_take_in(take), .mailbox_data_out(mb_data),
    .cpu_irq_out(cpu_irq), .board_reset_out(brst), .mst_req_in(mst_req), .mst_io_in(m_io),
    .mst_write_in(m_wr), .mst_wide_in(m_wide), .mst_addr_in(m_addr), .mst_wdata_in(16'hBEEF),
    .mst_done_out(done), .mst_timeout_out(m_tmo), .mst_rdata_out(m_rdata),
    .bus_prio_in_n_in(prio_n), .bus_busy_n_in(busy_n), .bus_xack_in(xack),
    .bus_cbrq_n_in(1'b1), .bus_rdata_in(b_rdata), .bus_req_out(b_req), .bus_prio_out_n_out(prio_o),
    .bus_busy_oe_out(), .bus_addr_out(b_addr), .bus_wdata_out(wd), .bus_data_oe_out(),
    .bus_mrd_out(mrd), .bus_mwr_out(mwr), .bus_iord_out(iord), .bus_iowr_out(iowr),
    .bus_byte_out(byte_n), .int_level_oe_out(oe), .bus_cycle_indicator_out(lamp));
  hpb_bus_model u_hpb_bus_model (.clk_in(sys_clk_in), .no_ack_in(no_ack), .slow_in(slow),
    .bus_req_in(b_req), .strobes_in({mrd, mwr, iord, iowr}), .bus_addr_in(b_addr),
    .bus_prio_in_n_out(prio_n), .bus_busy_n_out(busy_n), .bus_xack_out(xack),
    .bus_rdata_out(b_rdata));
  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic check(input logic [23:0] s, input logic [23:0] e);
    n_compared++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // One-cycle strobe; the answer stands in the cycle after it
  task automatic io(input logic rd, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_in) #1;
    {io_rd_in, io_wr_in, io_addr_in, io_wdata_in} = {rd, !rd, a, d};
    @(posedge sys_clk_in) #1;
    {io_rd_in, io_wr_in} = 2'b00;
    ack = io_ack_out;
    q = io_rdata_out;
  endtask : io
  task automatic status(input logic [7:0] e);
    io(1'b1, 16'h0001, 8'h00);
    check(ack, 1'b1);
    check(q, e);
  endtask : status
  task automatic pulse(ref logic s);
    @(posedge sys_clk_in) #1 s = 1'b1;
    @(posedge sys_clk_in) #1 s = 1'b0;
  endtask : pulse
  task automatic mst(input logic io_k, input logic wr, input logic [23:0] a);
    @(posedge sys_clk_in) #1;
    {mst_req, m_io, m_wr, m_wide, m_addr, seen} = {1'b1, io_k, wr, !wr, a, 4'h0};
    @(posedge sys_clk_in) #1 mst_req = 1'b0;
    for (int k = 0; k < 40 && done !== 1'b1; k++)
    begin
      if (lamp === 1'b1)
        {seen, asn, bw, pl} = {seen | {mrd, mwr, iord, iowr}, b_addr, byte_n, prio_o};
      @(posedge sys_clk_in) #1;
    end
    check(done, 1'b1);
    tmo = m_tmo;
  endtask : mst
  // ----------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------
  initial
  begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  // Whole sequence takes about 130 cycles; allow 6000, over forty times that
  initial
  begin
    #300000;
    errors++;
    results();
  end
  initial
  begin
    {arst_n_in, io_rd_in, io_wr_in, mem_rd_in, host_irq, take, mst_req} = 7'h00;
    {mem_wr, clk_en, prio_con} = 3'b011;
    {m_io, m_wr, m_wide, m_addr, no_ack, slow, st_pass, lb_fail} = 31'h0;
    {io_addr_in, io_wdata_in, low, high} = 39'h0;
    {wide, narrow, lvl} = {2'b10, IRQ_DEFAULT};
    repeat (20) @(posedge sys_clk_in);
    #1 arst_n_in = 1'b1;
    for (i = 0; i < 50 && brst !== 1'b0; i++) @(posedge sys_clk_in) #1;
    status(8'h00);
    {st_pass, lb_fail} = 2'b11;
    repeat (2) @(posedge sys_clk_in);
    status(8'h41);
    $display("test status done");
    io(1'b0, 16'h0001, 8'hC3);
    check({ack, cpu_irq, mb_data}, {2'b11, 8'hC3});
    status(8'h49);
    clk_en = 1'b0;
    pulse(take);
    check(cpu_irq, 1'b1);
    clk_en = 1'b1;
    pulse(take);
    status(8'h41);
    check(cpu_irq, 1'b0);
    $display("test mailbox done");
    pulse(host_irq);
    check(oe, 8'h20);
    status(8'h43);
    lvl = 8'h80;
    #1 check(oe, 8'h01);
    io(1'b0, 16'h0000, 8'h5A);
    check({ack, oe, mb_data}, {1'b1, 8'h00, 8'hC3});
    status(8'h41);
    $display("test interrupt done");
    pulse(mem_rd_in);
    check(io_ack_out, 1'b0);
    pulse(mem_wr);
    check(io_ack_out, 1'b0);
    for (i = 0; i < 7; i++)
    begin
      {wide, narrow, low, high} = DEC[i][17:1];
      io(1'b1, DEC[i][33:18], 8'h00);
      check(ack, DEC[i][0]);
    end
    {wide, narrow, low, high} = {2'b10, 15'h0};
    $display("test decode done");
    for (i = 0; i < 4; i++)
    begin
      slow = i[0];
      prio_con = i[1];
      mst(i[1], i[0], {i[1] ? 8'h00 : 8'hFE, 16'hDCB8 + 16'(i)});
      check(seen, 4'b1000 >> i);
      check(asn, {i[1] ? 8'h00 : 8'hFE, 16'hDCB8 + 16'(i)});
      check(bw, i[0]);
      if (!i[0]) check(m_rdata, 16'hDCB8 ^ 16'h5A5A ^ 16'(i));
      else check(wd, 16'hBEEF);
      check(pl, !i[1]);
    end
    no_ack = 1'b1;
    mst(1'b0, 1'b0, 24'h123456);
    check(tmo, 1'b1);
    no_ack = 1'b0;
    $display("test master done");
    io(1'b0, 16'h0001, 8'h77);
    st_pass = 1'b0;
    io(1'b1, 16'h0000, 8'h00);
    for (i = 0; i < 50 && brst === 1'b1; i++) @(posedge sys_clk_in) #1;
    check(i, RESET_PULSE_CYC);
    status(8'h40);
    $display("test board reset done");
    results();
  end
endmodule : hpb_host_port_tb
`default_nettype wire
